// [logic/vfw_pkg.sv]
// constants and types shared by the video frame writer design
package vfw_pkg;
    localparam int PIX_W = 8;
    localparam int WORD_W = 32;
    localparam int BE_W = 4;
    localparam int IDX_W = 3;
    localparam int NUM_BUFS = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [BE_W-1:0] BE_ALL = 4'hF;
    localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam int ALPHA_LSB = 24;
    localparam int RED_LSB = 16;
    localparam int GREEN_LSB = 8;
    localparam int BLUE_LSB = 0;
    localparam logic [PIX_W-1:0] ALPHA_FILL = 8'h00;
    // command and write-data port resets held for this many nanoseconds after block reset
    localparam int IF_RESET_NS = 100;
    localparam int CLK_PERIOD_NS = 10;
    localparam int IF_RESET_CYCLES = (IF_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCNT_W = 5;
    // command words sent per frame: base then the software command word
    localparam int CMD_WORDS = 2;

    typedef enum logic [2:0] {
        VFW_RESET_IF, VFW_WAIT_READY, VFW_WAIT_SYNC, VFW_CMD_BASE, VFW_CMD_WORD, VFW_ACTIVE
    } vfw_state_type;
endpackage

// [logic/vfw_fifo_if.sv]
// handshake bundle between the writer core and its pixel fifo
`timescale 1ns/1ps
interface vfw_fifo_if #(parameter int WIDTH = 32);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport src (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
    modport fifo (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
endinterface

// [logic/vfw_fifo.sv]
// small synchronous fifo holding pixel words, registered read data
`timescale 1ns/1ps
module vfw_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // stream ports
    vfw_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] rd_data;
    logic rd_valid;
    wire push = f.in_valid && f.in_ready;
    wire pop_mem = (count != '0) && (!rd_valid || f.out_ready);
    wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop_mem);

    assign f.in_ready = (count != (AW+1)'(DEPTH));
    assign f.out_valid = rd_valid;
    assign f.out_data = rd_data;

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr] <= f.in_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop_mem) begin
                rd_ptr <= rd_ptr + 1'b1;
                rd_data <= mem[rd_ptr];
                rd_valid <= 1'b1;
            end else if (f.out_ready) begin
                rd_valid <= 1'b0;
            end
            count <= next_count;
        end
    end
endmodule // vfw_fifo

// [logic/vfw_frame_writer.sv]
// video frame writer: stores incoming video frames into memory buffers
// Operation
// - vertical sync advances the frame counter to the next buffer
// - after advancing, two command words starting that buffer (base, then command word) go to the command port
// - after the command, active-video pixels are written into the data fifo
// - writing continues into the current buffer until the next vertical sync
// - current frame index is output as a three-bit gray code
// - hold-frame input stops the frame counter from advancing
// - pixel words are 32 bits with a 4-bit byte enable
// - command words leave on a 32-bit output
// - one write strobe per data word pushed to the memory fifo
// - block supplies the clocks for write-data and command ports
// - block drives reset outputs to command and write-data ports
// - completion output rises once a frame capture has finished
// - buffer bases and command words come from software-written inputs
`timescale 1ns/1ps
module vfw_frame_writer
    import vfw_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // readiness and control
    input wire logic i_mem_init_done,
    input wire logic i_clock_locked,
    input wire logic i_hold_frame,
    input wire logic i_field_parity,
    // video stream
    input wire logic i_active_video_in,
    input wire logic i_vsync,
    input wire logic i_hsync,
    input wire logic [PIX_W-1:0] i_red,
    input wire logic [PIX_W-1:0] i_green,
    input wire logic [PIX_W-1:0] i_blue,
    // software configuration
    input wire logic [WORD_W-1:0] i_buf_base [NUM_BUFS],
    input wire logic [WORD_W-1:0] i_cmd_word,
    // memory write-data port
    output logic o_wrport_clock,
    output logic o_wrport_reset,
    output logic o_wrport_strobe,
    output logic [WORD_W-1:0] o_wrport_word,
    output logic [BE_W-1:0] o_wrport_byte_enables,
    input wire logic i_wrport_full,
    // memory command port
    output logic o_cmdport_clock,
    output logic o_cmdport_reset,
    output logic o_cmdport_strobe,
    output logic [WORD_W-1:0] o_cmdport_word,
    // status
    output logic [IDX_W-1:0] o_gray_frame_index,
    output logic o_frame_end_flag,
    output logic o_last_frame_done,
    output logic o_field_captured,
    output logic o_pixel_dropped
);
    function automatic logic [IDX_W-1:0] bin2gray(input logic [IDX_W-1:0] b);
        return b ^ (b >> 1);
    endfunction

    // two-stage synchronisers for the video, readiness and control inputs from pins
    logic [1:0] s_vsync, s_de, s_init, s_lock, s_hold, s_field, s_hsync;
    logic [PIX_W-1:0] r1_red, r1_green, r1_blue, r2_red, r2_green, r2_blue;
    logic vsync_d;

    // readiness and control levels
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s_init <= '0;
            s_lock <= '0;
            s_hold <= '0;
            s_field <= '0;
        end else begin
            s_init <= {s_init[0], i_mem_init_done};
            s_lock <= {s_lock[0], i_clock_locked};
            s_hold <= {s_hold[0], i_hold_frame};
            s_field <= {s_field[0], i_field_parity};
        end
    end

    // sync and enable; a sync already high at release shows as an edge,
    // harmless because the ports are still held in reset then
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s_vsync <= '0;
            s_de <= '0;
            s_hsync <= '0;
            vsync_d <= 1'b0;
        end else begin
            s_vsync <= {s_vsync[0], i_vsync};
            s_de <= {s_de[0], i_active_video_in};
            s_hsync <= {s_hsync[0], i_hsync};
            vsync_d <= s_vsync[1];
        end
    end

    // colour pipe: two stages so pixels line up with the synced enable
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            r1_red <= '0;
            r1_green <= '0;
            r1_blue <= '0;
            r2_red <= '0;
            r2_green <= '0;
            r2_blue <= '0;
        end else begin
            r1_red <= i_red;
            r1_green <= i_green;
            r1_blue <= i_blue;
            r2_red <= r1_red;
            r2_green <= r1_green;
            r2_blue <= r1_blue;
        end
    end

    wire vsync_rise = s_vsync[1] && !vsync_d;
    wire de_s = s_de[1];
    wire sys_ready = s_init[1] && s_lock[1];
    // pixel packed as 0RGB, all four byte lanes written
    wire [WORD_W-1:0] pixel_word = {ALPHA_FILL, r2_red, r2_green, r2_blue};

    vfw_state_type state, next_state;
    logic [IDX_W-1:0] frame_idx;
    logic [RCNT_W-1:0] rst_cnt;
    logic capturing;
    logic cmd_strobe;
    logic [WORD_W-1:0] cmd_word;
    logic [IDX_W-1:0] gray_idx;
    logic frame_end;
    logic frame_done;
    logic field_cap;
    logic dropped;

    vfw_fifo_if #(.WIDTH(WORD_W)) pix_if ();

    vfw_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .f(pix_if.fifo)
    );

    // only push while the frame's command has gone out and video is active
    wire push_req = (state == VFW_ACTIVE) && de_s;
    assign pix_if.in_valid = push_req;
    assign pix_if.in_data = pixel_word;
    // controller full flag stalls draining so the fifo absorbs bursts
    assign pix_if.out_ready = !i_wrport_full && sys_ready;
    wire drain = pix_if.out_valid && pix_if.out_ready;

    wire cmd_base_go = (state == VFW_CMD_BASE);
    wire cmd_word_go = (state == VFW_CMD_WORD);
    wire [IDX_W-1:0] next_idx = s_hold[1] ? frame_idx : frame_idx + 1'b1;

    always_comb begin
        next_state = state;
        case (state)
            VFW_RESET_IF: begin
                if (rst_cnt == RCNT_W'(IF_RESET_CYCLES)) next_state = VFW_WAIT_READY;
            end
            VFW_WAIT_READY: begin
                if (sys_ready) next_state = VFW_WAIT_SYNC;
            end
            VFW_WAIT_SYNC: begin
                if (vsync_rise) next_state = VFW_CMD_BASE;
            end
            VFW_CMD_BASE: begin
                next_state = VFW_CMD_WORD;
            end
            VFW_CMD_WORD: begin
                next_state = VFW_ACTIVE;
            end
            VFW_ACTIVE: begin
                if (!sys_ready) next_state = VFW_WAIT_READY;
                else if (vsync_rise) next_state = VFW_CMD_BASE;
            end
            default: begin
                next_state = VFW_RESET_IF;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state <= VFW_RESET_IF;
        end else begin
            state <= next_state;
        end
    end

    // counter only runs while the ports are held, so it cannot wrap
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rst_cnt <= '0;
        end else if (state == VFW_RESET_IF) begin
            rst_cnt <= rst_cnt + 1'b1;
        end
    end

    // a sync is only honoured once the ports are ready
    wire sync_accept = vsync_rise && (state == VFW_ACTIVE || state == VFW_WAIT_SYNC);

    // frame counter; hold keeps rewriting the same buffer
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            frame_idx <= IDX_RESET;
        end else if (sync_accept) begin
            frame_idx <= next_idx;
        end
    end

    // command strobe covers both words of a frame start
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cmd_strobe <= 1'b0;
        end else begin
            cmd_strobe <= cmd_base_go || cmd_word_go;
        end
    end

    // command words: buffer base first, then the software command word
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cmd_word <= WORD_ZERO;
        end else if (cmd_base_go) begin
            cmd_word <= i_buf_base[frame_idx];
        end else if (cmd_word_go) begin
            cmd_word <= i_cmd_word;
        end
    end

    // index and frame_end_flag; done lasts until the next base command,
    // and the set wins should both ever fall in one cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            gray_idx <= bin2gray(IDX_RESET);
            frame_end <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            gray_idx <= bin2gray(frame_idx);
            frame_end <= vsync_rise && capturing;
            if (vsync_rise && capturing) begin
                frame_done <= 1'b1;
            end else if (cmd_base_go) begin
                frame_done <= 1'b0;
            end
        end
    end

    // losing readiness mid-frame ends the capture; the next sync restarts it
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            capturing <= 1'b0;
            field_cap <= 1'b0;
        end else if (cmd_word_go) begin
            capturing <= 1'b1;
            field_cap <= s_field[1];
        end else if (state == VFW_WAIT_READY) begin
            capturing <= 1'b0;
        end
    end

    // a pixel lost to a full fifo is sticky until reset
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            dropped <= 1'b0;
        end else if (push_req && !pix_if.in_ready) begin
            dropped <= 1'b1;
        end
    end

    // interface clocks run at half the core clock from registered toggles
    logic port_clk;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            port_clk <= 1'b0;
        end else begin
            port_clk <= ~port_clk;
        end
    end

    // port clocks and resets; both ports share one clock phase
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_wrport_clock <= 1'b0;
            o_cmdport_clock <= 1'b0;
            o_wrport_reset <= 1'b1;
            o_cmdport_reset <= 1'b1;
        end else begin
            o_wrport_clock <= port_clk;
            o_cmdport_clock <= port_clk;
            o_wrport_reset <= (state == VFW_RESET_IF);
            o_cmdport_reset <= (state == VFW_RESET_IF);
        end
    end

    // write-data port: all four byte lanes enabled, the top lane carrying the zero alpha fill
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_wrport_strobe <= 1'b0;
            o_wrport_word <= WORD_ZERO;
            o_wrport_byte_enables <= '0;
        end else begin
            o_wrport_strobe <= drain;
            o_wrport_word <= pix_if.out_data;
            o_wrport_byte_enables <= drain ? BE_ALL : '0;
        end
    end

    // command port
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_cmdport_strobe <= 1'b0;
            o_cmdport_word <= WORD_ZERO;
        end else begin
            o_cmdport_strobe <= cmd_strobe;
            o_cmdport_word <= cmd_word;
        end
    end

    // status towards the display side and software
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_gray_frame_index <= bin2gray(IDX_RESET);
            o_frame_end_flag <= 1'b0;
            o_last_frame_done <= 1'b0;
            o_field_captured <= 1'b0;
            o_pixel_dropped <= 1'b0;
        end else begin
            o_gray_frame_index <= gray_idx;
            o_frame_end_flag <= frame_end;
            o_last_frame_done <= frame_done;
            o_field_captured <= field_cap;
            o_pixel_dropped <= dropped;
        end
    end
endmodule // vfw_frame_writer

// [verification/vfw_properties.sv]
// port-level checks on the frame writer
`timescale 1ns/1ps
module vfw_properties
    import vfw_pkg::*;
(
    // clock, reset, control
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_mem_init_done,
    input wire logic i_clock_locked,
    input wire logic i_hold_frame,
    input wire logic [WORD_W-1:0] i_cmd_word,
    // memory ports and status
    input wire logic o_wrport_clock,
    input wire logic o_wrport_reset,
    input wire logic o_wrport_strobe,
    input wire logic [BE_W-1:0] o_wrport_byte_enables,
    input wire logic o_cmdport_clock,
    input wire logic o_cmdport_reset,
    input wire logic o_cmdport_strobe,
    input wire logic [WORD_W-1:0] o_cmdport_word,
    input wire logic [IDX_W-1:0] o_gray_frame_index,
    input wire logic o_frame_end_flag
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence seq_not_ready;
        (!i_mem_init_done || !i_clock_locked)[*3];
    endsequence
    sequence seq_cmd_pair;
        o_cmdport_strobe ##1 o_cmdport_strobe ##1 !o_cmdport_strobe;
    endsequence
    a_idle_until_ready: assert property (seq_not_ready |-> !o_cmdport_strobe && !o_wrport_strobe)
        else $error("port activity before ready");
    a_cmd_two_words: assert property ($rose(o_cmdport_strobe) |-> seq_cmd_pair)
        else $error("command strobe not two cycles");
    a_cmd_second_word: assert property (o_cmdport_strobe && $past(o_cmdport_strobe) |-> o_cmdport_word == i_cmd_word)
        else $error("second command word wrong");
    a_gray_one_bit: assert property ($changed(o_gray_frame_index) |-> $countones(o_gray_frame_index ^ $past(o_gray_frame_index)) == 1)
        else $error("gray index changed more than one bit");
    a_hold_freezes: assert property (i_hold_frame[*5] |=> $stable(o_gray_frame_index))
        else $error("index moved while held");
    a_byte_enables: assert property (o_wrport_byte_enables == (o_wrport_strobe ? BE_ALL : 4'h0))
        else $error("byte enables wrong");
    a_end_then_cmd: assert property (o_frame_end_flag |=> !o_frame_end_flag ##[0:8] $rose(o_cmdport_strobe))
        else $error("frame end not followed by command");
    a_port_clocks: assert property ($past(i_rst_n, 2) |-> o_wrport_clock != $past(o_wrport_clock) && o_cmdport_clock == o_wrport_clock)
        else $error("port clocks not core over two");
    a_ports_reset: assert property (disable iff (1'b0) !i_rst_n |=> o_wrport_reset && o_cmdport_reset && !o_cmdport_strobe)
        else $error("port resets not driven in reset");
endmodule // vfw_properties
bind vfw_frame_writer vfw_properties u_props (.i_mclk, .i_rst_n, .i_mem_init_done, .i_clock_locked,
    .i_hold_frame, .i_cmd_word, .o_wrport_clock, .o_wrport_reset, .o_wrport_strobe,
    .o_wrport_byte_enables, .o_cmdport_clock, .o_cmdport_reset, .o_cmdport_strobe,
    .o_cmdport_word, .o_gray_frame_index, .o_frame_end_flag);

// [verification/vfw_mem_model.sv]
// memory controller stand-in: logs command and data words
`timescale 1ns/1ps
module vfw_mem_model
    import vfw_pkg::*;
(
    // clock and stall control
    input wire logic i_mclk,
    input wire logic i_stall,
    // ports from the writer
    input wire logic i_wr_reset,
    input wire logic i_wr_strobe,
    input wire logic [WORD_W-1:0] i_wr_word,
    input wire logic i_cmd_reset,
    input wire logic i_cmd_strobe,
    input wire logic [WORD_W-1:0] i_cmd_word,
    // back-pressure
    output logic o_full
);
    logic [WORD_W-1:0] wr_q [$];
    logic [WORD_W-1:0] cmd_q [$];
    // full follows the stall request at once, the harshest case for the writer
    assign o_full = i_stall;
    always @(posedge i_mclk) begin
        if (!i_wr_reset && i_wr_strobe) wr_q.push_back(i_wr_word);
        if (!i_cmd_reset && i_cmd_strobe) cmd_q.push_back(i_cmd_word);
    end
endmodule // vfw_mem_model

// [verification/test_vfw_frame_writer.sv]
// self-checking bench for the video frame writer
`timescale 1ns/1ps
module test_vfw_frame_writer;
    import vfw_pkg::*;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_mem_init_done = 1'b0, i_clock_locked = 1'b0;
    logic i_hold_frame = 1'b0, i_field_parity = 1'b0, i_active_video_in = 1'b0;
    logic i_vsync = 1'b0, i_hsync = 1'b0, stall = 1'b0, i_wrport_full;
    logic [PIX_W-1:0] i_red = 8'h3C, i_green = 8'h00, i_blue = 8'h00;
    logic [WORD_W-1:0] i_buf_base [NUM_BUFS] = '{32'h1000, 32'h2100, 32'h3200, 32'h4300,
        32'h5400, 32'h6500, 32'h7600, 32'h8700};
    logic [WORD_W-1:0] i_cmd_word = 32'hC0DE_0042, o_wrport_word, o_cmdport_word;
    logic o_wrport_clock, o_wrport_reset, o_wrport_strobe, o_cmdport_clock, o_cmdport_reset;
    logic o_cmdport_strobe, o_frame_end_flag, o_last_frame_done, o_field_captured;
    logic o_pixel_dropped;
    logic [BE_W-1:0] o_wrport_byte_enables;
    logic [IDX_W-1:0] o_gray_frame_index;
    int n_errors = 0, tests_run = 0, n_end = 0, n_done = 0, f;
    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (o_frame_end_flag === 1'b1) n_end++;
    always @(posedge i_mclk) if (o_last_frame_done === 1'b1) n_done++;
    vfw_frame_writer DUT (.i_mclk, .i_rst_n, .i_mem_init_done, .i_clock_locked, .i_hold_frame,
        .i_field_parity, .i_active_video_in, .i_vsync, .i_hsync, .i_red, .i_green, .i_blue,
        .i_buf_base, .i_cmd_word, .o_wrport_clock, .o_wrport_reset, .o_wrport_strobe,
        .o_wrport_word, .o_wrport_byte_enables, .i_wrport_full, .o_cmdport_clock,
        .o_cmdport_reset, .o_cmdport_strobe, .o_cmdport_word, .o_gray_frame_index,
        .o_frame_end_flag, .o_last_frame_done, .o_field_captured, .o_pixel_dropped);
    vfw_mem_model MEM (.i_mclk, .i_stall(stall), .i_wr_reset(o_wrport_reset),
        .i_wr_strobe(o_wrport_strobe), .i_wr_word(o_wrport_word),
        .i_cmd_reset(o_cmdport_reset), .i_cmd_strobe(o_cmdport_strobe),
        .i_cmd_word(o_cmdport_word), .o_full(i_wrport_full));
    task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic complete_run();
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // bounded wait for the model to log n words
    task automatic wait_q(input int n, input bit is_cmd);
        int k;
        for (k = 0; k < 60; k++) begin
            if ((is_cmd ? MEM.cmd_q.size() : MEM.wr_q.size()) >= n) return;
            @(posedge i_mclk);
        end
        n_errors++;
        complete_run();
    endtask
    task automatic pixels(input int n);
        int p;
        for (p = 0; p < n; p++) begin
            i_active_video_in <= 1'b1;
            i_green <= p[7:0];
            i_blue <= ~p[7:0];
            @(posedge i_mclk);
        end
        i_active_video_in <= 1'b0;
    endtask
    task automatic drain(input int n);
        int p;
        wait_q(n, 1'b0);
        repeat (6) @(posedge i_mclk);
        for (p = 0; p < n; p++) chk_word(MEM.wr_q.pop_front(), {8'h00, 8'h3C, p[7:0], ~p[7:0]});
        chk_flag(MEM.wr_q.size() == 0, 1'b1);
    endtask
    task automatic frame(input logic [2:0] idx, input int n, input logic par);
        i_field_parity <= par;
        i_vsync <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_vsync <= 1'b0;
        wait_q(2, 1'b1);
        chk_word(MEM.cmd_q.pop_front(), i_buf_base[idx]);
        chk_word(MEM.cmd_q.pop_front(), i_cmd_word);
        chk_word({29'h0, o_gray_frame_index}, {29'h0, idx ^ (idx >> 1)});
        repeat (4) @(posedge i_mclk);
        chk_flag(o_field_captured, par);
        pixels(n);
    endtask
    initial begin
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        // sync and video while not ready must leave the ports silent
        i_vsync <= 1'b1;
        i_active_video_in <= 1'b1;
        repeat (30) @(posedge i_mclk);
        i_mem_init_done <= 1'b1;
        repeat (30) @(posedge i_mclk);
        i_vsync <= 1'b0;
        i_active_video_in <= 1'b0;
        chk_flag(MEM.cmd_q.size() == 0 && MEM.wr_q.size() == 0, 1'b1);
        i_clock_locked <= 1'b1;
        repeat (8) @(posedge i_mclk);
        for (f = 1; f <= 9; f++) begin
            frame(f[2:0], 4 + f, f[0]);
            drain(4 + f);
        end
        i_hold_frame <= 1'b1;
        repeat (4) @(posedge i_mclk);
        frame(3'h1, 3, 1'b0);
        drain(3);
        i_hold_frame <= 1'b0;
        stall <= 1'b1;
        frame(3'h2, 6, 1'b1);
        repeat (4) @(posedge i_mclk);
        chk_flag(MEM.wr_q.size() == 0, 1'b1);
        stall <= 1'b0;
        drain(6);
        chk_flag(o_pixel_dropped, 1'b0);
        stall <= 1'b1;
        pixels(16);
        repeat (4) @(posedge i_mclk);
        stall <= 1'b0;
        chk_flag(o_pixel_dropped, 1'b1);
        repeat (20) @(posedge i_mclk);
        chk_word(32'(n_end), 32'hA);
        chk_word(32'(n_done), 32'hA);
        chk_flag(o_last_frame_done, 1'b0);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        chk_flag(o_cmdport_reset & o_wrport_reset, 1'b1);
        complete_run();
    end
endmodule // test_vfw_frame_writer
